/* File: clock_gen_pkg.sv */
// Purpose: constants and types for the CPU clock and baud generator
// Assumes: core_clk stands in for the PLL tap at MODEL_MHZ
// Notes:   all offsets, reset values and divider counts live here
//
// How it works
// RL1 - a PLL multiplies the crystal to the link rate; counters divide it.
// RL2 - after reset the CPU clock runs at 12 MHz until firmware picks one.
// RL3 - firmware may rewrite the speed field at any time; it applies live.
// RL4 - the clock pin copies the CPU clock at 48, 24 or 12 MHz, 50% duty.
// RL5 - two separate control bits tri-state and invert the clock pin.
// RL6 - a baud source pulses for 230 KBaud on both ports within 1%.
// RL7 - the baud interval tracks the CPU speed so the bit rate holds.
// RL8 - the two-wire controller is master only, clocking at 100 or 400 kHz.
// RL9 - a set baud doubling bit runs that port at 115 KBaud instead.
// RL10 - a speed change never shortens a high or low clock pulse.
package clock_gen_pkg;

  localparam int          ADDR_W = 4;
  localparam int          DATA_W = 8;

  // register offsets
  localparam logic [3:0]  ADDR_CPU_CTRL = 4'h0;
  localparam logic [3:0]  ADDR_SER_CTRL = 4'h1;
  localparam logic [7:0]  CPU_CTRL_RESET = 8'h00;
  localparam logic [7:0]  SER_CTRL_RESET = 8'h00;

  // speed field codes
  localparam logic [1:0]  SPEED_12 = 2'h0;
  localparam logic [1:0]  SPEED_24 = 2'h1;
  localparam logic [1:0]  SPEED_48 = 2'h2;

  // clock tree figures
  localparam int          XTAL_MHZ  = 24;
  localparam int          PLL_MHZ   = 480;
  localparam int          PLL_MULT  = PLL_MHZ / XTAL_MHZ;
  localparam int          MODEL_DIV = 5;
  localparam int          MODEL_MHZ = PLL_MHZ / MODEL_DIV;
  localparam logic [2:0]  HALF_48 = 3'(MODEL_MHZ / (2 * 48));
  localparam logic [2:0]  HALF_24 = 3'(MODEL_MHZ / (2 * 24));
  localparam logic [2:0]  HALF_12 = 3'(MODEL_MHZ / (2 * 12));

  // baud source, counted in CPU clock periods
  localparam int          BAUD_RATE = 230400;
  localparam logic [7:0]  BAUD_CNT_48 = 8'(48000000 / BAUD_RATE);
  localparam logic [7:0]  BAUD_CNT_24 = 8'(24000000 / BAUD_RATE);
  localparam logic [7:0]  BAUD_CNT_12 = 8'(12000000 / BAUD_RATE);

  // two-wire serial clock half periods, in CPU clock periods
  localparam int          SCL_STD_HZ  = 100000;
  localparam int          SCL_FAST_HZ = 400000;
  localparam logic [7:0]  SCL_STD_48  = 8'(48000000 / (2 * SCL_STD_HZ));
  localparam logic [7:0]  SCL_STD_24  = 8'(24000000 / (2 * SCL_STD_HZ));
  localparam logic [7:0]  SCL_STD_12  = 8'(12000000 / (2 * SCL_STD_HZ));
  localparam logic [7:0]  SCL_FAST_48 = 8'(48000000 / (2 * SCL_FAST_HZ));
  localparam logic [7:0]  SCL_FAST_24 = 8'(24000000 / (2 * SCL_FAST_HZ));
  localparam logic [7:0]  SCL_FAST_12 = 8'(12000000 / (2 * SCL_FAST_HZ));

  typedef struct packed {
    logic [3:0] unused;
    logic       tristate;
    logic       invert;
    logic [1:0] speed;
  } cpu_ctrl_type;

  typedef struct packed {
    logic [4:0] unused;
    logic       scl_fast;
    logic       double_one;
    logic       double_zero;
  } ser_ctrl_type;

endpackage : clock_gen_pkg

/* File: cpu_clock_gen.sv */
// Purpose: CPU clock divider, clock output pin, baud and serial clock ticks
// Assumes: register strobes are synchronous to core_clk
// Notes:   speed changes take effect only at the end of a high phase
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/10ps
module cpu_clock_gen
  import clock_gen_pkg::*;
(
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [DATA_W-1:0] reg_rdata,
  // clocks out
  output logic                   cpu_clock,
  output logic                   clk_pin_out,
  output logic                   clk_pin_oe,
  // serial timing
  output logic                   baud_tick_zero,
  output logic                   baud_tick_one,
  output logic                   scl_tick
);

  cpu_ctrl_type ctrl_q;
  cpu_ctrl_type ctrl_d;
  ser_ctrl_type ser_q;
  logic [1:0]   speed_q;
  logic [2:0]   cnt_q;
  logic [2:0]   ph_len_q;
  logic         cpu_q;
  logic [7:0]   baud_cnt_q;
  logic [7:0]   scl_cnt_q;
  logic         half_zero_q;
  logic         half_one_q;
  logic         tick_zero_q;
  logic         tick_one_q;
  logic         scl_q;
  logic         pin_q;
  logic         oe_q;
  logic [7:0]   rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  wire          cpu_wr  = reg_wr && (reg_addr == ADDR_CPU_CTRL);
  wire          ser_wr  = reg_wr && (reg_addr == ADDR_SER_CTRL);
  wire [7:0]    cpu_rd  = {2'h0, speed_q, ctrl_q[3:0]};
  wire [7:0]    rd_mux  = (reg_addr == ADDR_CPU_CTRL) ? cpu_rd :
                          (reg_addr == ADDR_SER_CTRL) ? {5'h00, ser_q[2:0]} :
                          8'h00;
  assign ctrl_d = cpu_wr ? cpu_ctrl_type'({4'h0, reg_wdata[3:0]}) : ctrl_q;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_q  <= cpu_ctrl_type'(CPU_CTRL_RESET);  // RL2
      ser_q   <= ser_ctrl_type'(SER_CTRL_RESET);
      rdata_q <= 8'h00;
    end
    else
    begin
      ctrl_q  <= ctrl_d;  // RL3
      if (ser_wr)
        ser_q <= ser_ctrl_type'({5'h00, reg_wdata[2:0]});
      rdata_q <= reg_rd ? rd_mux : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU clock divider

  // reserved speed code 3 falls back to the slowest rate
  wire [1:0]    req_speed = (ctrl_q.speed == 2'h3) ? SPEED_12 : ctrl_q.speed;
  wire [2:0]    half_lim  = (speed_q == SPEED_48) ? HALF_48 :       // RL1
                            (speed_q == SPEED_24) ? HALF_24 : HALF_12;
  wire          toggle    = (cnt_q == half_lim - 3'h1);
  wire          cpu_rise  = toggle && !cpu_q;
  wire          cpu_d     = toggle ? !cpu_q : cpu_q;

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      speed_q  <= SPEED_12;  // RL2
      cnt_q    <= 3'h0;
      cpu_q    <= 1'b0;
      pin_q    <= 1'b0;
      oe_q     <= !CPU_CTRL_RESET[3];
      ph_len_q <= 3'h1;
    end
    else
    begin
      cnt_q    <= toggle ? 3'h0 : cnt_q + 3'h1;  // RL4
      cpu_q    <= cpu_d;
      pin_q    <= cpu_d ^ ctrl_d.invert;  // RL5
      // own flop, so the pin enable leaves no gate glitch
      oe_q     <= !ctrl_d.tristate;  // RL5
      ph_len_q <= toggle ? 3'h1 : ph_len_q + 3'h1;
      // only at a falling edge, so both phases stay whole
      if (toggle && cpu_q)
        speed_q <= req_speed;  // RL10
    end
  end

  assign cpu_clock   = cpu_q;
  assign clk_pin_out = pin_q;
  assign clk_pin_oe  = oe_q;
  assign reg_rdata   = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // baud source and two-wire clock

  wire [7:0]    baud_lim = (speed_q == SPEED_48) ? BAUD_CNT_48 :  // RL7
                           (speed_q == SPEED_24) ? BAUD_CNT_24 : BAUD_CNT_12;
  wire [7:0]    scl_lim  = ser_q.scl_fast ?
                           ((speed_q == SPEED_48) ? SCL_FAST_48 :
                            (speed_q == SPEED_24) ? SCL_FAST_24 : SCL_FAST_12) :
                           ((speed_q == SPEED_48) ? SCL_STD_48 :
                            (speed_q == SPEED_24) ? SCL_STD_24 : SCL_STD_12);
  // >= keeps a count left over from a faster rate from running away
  wire          baud_ovf = cpu_rise && (baud_cnt_q >= baud_lim - 8'h01);
  wire          scl_ovf  = cpu_rise && (scl_cnt_q >= scl_lim - 8'h01);

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      baud_cnt_q  <= 8'h00;
      scl_cnt_q   <= 8'h00;
      half_zero_q <= 1'b0;
      half_one_q  <= 1'b0;
      tick_zero_q <= 1'b0;
      tick_one_q  <= 1'b0;
      scl_q       <= 1'b0;
    end
    else
    begin
      if (cpu_rise)
      begin
        baud_cnt_q <= baud_ovf ? 8'h00 : baud_cnt_q + 8'h01;  // RL6
        scl_cnt_q  <= scl_ovf ? 8'h00 : scl_cnt_q + 8'h01;  // RL8
      end
      half_zero_q <= half_zero_q ^ baud_ovf;
      half_one_q  <= half_one_q ^ baud_ovf;
      tick_zero_q <= baud_ovf && (!ser_q.double_zero || half_zero_q);  // RL9
      tick_one_q  <= baud_ovf && (!ser_q.double_one || half_one_q);  // RL9
      scl_q       <= scl_ovf;  // RL8
    end
  end

  assign baud_tick_zero = tick_zero_q;
  assign baud_tick_one  = tick_one_q;
  assign scl_tick       = scl_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  AST_RESET_SLOW: assert property (  // RL2
    @(posedge core_clk) $fell(reset) |-> speed_q == SPEED_12)
    else $error("speed not slowest after reset");

  AST_PHASE_HIGH: assert property (  // RL4
    @(posedge core_clk) disable iff (reset)
    (toggle && cpu_q) |-> ph_len_q == half_lim)
    else $error("cpu clock high phase wrong length");

  AST_PHASE_LOW: assert property (  // RL10
    @(posedge core_clk) disable iff (reset)
    (toggle && !cpu_q) |-> ph_len_q == half_lim)
    else $error("cpu clock low phase shortened");

  AST_PIN_POLARITY: assert property (  // RL5
    @(posedge core_clk) disable iff (reset)
    clk_pin_out == (cpu_clock ^ ctrl_q.invert))
    else $error("clock pin not a copy of cpu clock");

  AST_PIN_TRISTATE: assert property (  // RL5
    @(posedge core_clk) disable iff (reset)
    cpu_wr |=> clk_pin_oe == !$past(reg_wdata[3]))
    else $error("clock pin enable not following control");

  AST_SPEED_APPLY: assert property (  // RL3
    @(posedge core_clk) disable iff (reset)
    (cpu_wr && reg_wdata[1:0] != 2'h3) ##1 (!cpu_wr)[*8] ##1 !cpu_wr
    |-> speed_q == ctrl_q.speed)
    else $error("new speed not applied in time");

  AST_BAUD_OVF: assert property (  // RL6
    @(posedge core_clk) disable iff (reset)
    baud_ovf |=> baud_cnt_q == 8'h00)
    else $error("baud overflow off its count");

  AST_SPEED_GATE: assert property (  // RL10
    @(posedge core_clk) disable iff (reset)
    (speed_q != $past(speed_q)) |-> $past(toggle && cpu_q))
    else $error("speed changed outside a falling edge");

  AST_BAUD_FULL: assert property (  // RL9
    @(posedge core_clk) disable iff (reset)
    (baud_ovf && !ser_q.double_zero) |=> baud_tick_zero)
    else $error("port zero missed a baud tick");

  AST_BAUD_HALF: assert property (  // RL9
    @(posedge core_clk) disable iff (reset)
    (baud_ovf && ser_q.double_one && !half_one_q) |=> !baud_tick_one)
    else $error("port one not halved");

  AST_SCL_TICK: assert property (  // RL8
    @(posedge core_clk) disable iff (reset)
    scl_tick |-> $past(cpu_rise) && $past(scl_cnt_q) >= $past(scl_lim) - 8'h01)
    else $error("serial clock tick off its count");

  COV_FAST_CPU: cover property (
    @(posedge core_clk) disable iff (reset) speed_q == SPEED_48 && toggle);
  COV_HALF_BAUD: cover property (
    @(posedge core_clk) disable iff (reset)
    baud_tick_one && ser_q.double_one);
  COV_SCL_FAST: cover property (
    @(posedge core_clk) disable iff (reset) scl_tick && ser_q.scl_fast);

endmodule : cpu_clock_gen

/* File: pin_watch.sv */
// Purpose: far-side logic that times the clock output pin
// Assumes: the pin is sampled on every core_clk rising edge
// Notes:   no pull on the pin, so a released pin shows its inverse level
`timescale 1ns/10ps
module pin_watch
(
  // sampling clock
  input  wire logic core_clk,
  // pin
  input  wire logic clk_pin_out,
  input  wire logic clk_pin_oe,
  // last phase lengths in core_clk cycles
  output int        hi_len,
  output int        lo_len
);
  logic last_q = 1'b0;
  logic prev_q = 1'b0;
  logic pin;
  int   run = 0;
  // a floating pin must not pass for its old level
  assign pin = clk_pin_oe ? clk_pin_out : ~last_q;
  always @(posedge core_clk)
  begin
    if (clk_pin_oe)
      last_q <= clk_pin_out;
    prev_q <= pin;
    if (pin !== prev_q)
    begin
      if (prev_q)
        hi_len <= run;
      else
        lo_len <= run;
      run <= 1;
    end
    else
      run <= run + 1;
  end
endmodule : pin_watch

/* File: tb_cpu_clock_gen.sv */
// Purpose: self-checking bench for the CPU clock and baud generator
// Assumes: tick spacing in core_clk cycles is the same at every speed
// Notes:   each scenario is one task that drives and judges
`timescale 1ns/10ps
module tb_cpu_clock_gen
  import clock_gen_pkg::*;
;
  logic              core_clk, reset, reg_wr, reg_rd;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
  logic              cpu_clock, clk_pin_out, clk_pin_oe;
  logic              baud_tick_zero, baud_tick_one, scl_tick;
  logic [2:0]        ev;
  int                mismatches = 0, samples_checked = 0, hi_len, lo_len;
  assign ev = {scl_tick, baud_tick_one, baud_tick_zero};
  cpu_clock_gen i_cpu_clock_gen (.core_clk(core_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_clock(cpu_clock),
    .clk_pin_out(clk_pin_out), .clk_pin_oe(clk_pin_oe),
    .baud_tick_zero(baud_tick_zero), .baud_tick_one(baud_tick_one),
    .scl_tick(scl_tick));
  pin_watch i_pin_watch (.core_clk(core_clk), .clk_pin_out(clk_pin_out),
    .clk_pin_oe(clk_pin_oe), .hi_len(hi_len), .lo_len(lo_len));
  //////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chkn(input int got, input int exp);
    samples_checked++;
    if (got != exp)
    begin
      mismatches++;
      $display("unexpected at %0t: count %0d want %0d", $time, got, exp);
    end
  endtask : chkn
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd
  // spacing of two ticks; the first two are skipped to let counters settle
  task automatic gap(input int s, output int n);
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      do begin @(posedge core_clk); n++; end
      while (ev[s] !== 1'b1 && n < 2000);
    end
  endtask : gap
  //////////////////////////////////////////////////////////////////////////
  task automatic t_speed;
    logic [1:0] c[3] = '{SPEED_24, SPEED_12, SPEED_48};
    int         h[3] = '{HALF_24, HALF_12, HALF_48};
    rd(ADDR_CPU_CTRL); chk8(d, CPU_CTRL_RESET);
    rd(ADDR_SER_CTRL); chk8(d, SER_CTRL_RESET);
    repeat (30) @(posedge core_clk);
    chkn(hi_len, HALF_12); chkn(lo_len, HALF_12);
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_CPU_CTRL, {6'h0, c[i]});
      repeat (30) @(posedge core_clk);
      rd(ADDR_CPU_CTRL); chk8(d, {2'h0, c[i], 2'h0, c[i]});
      chkn(hi_len, h[i]); chkn(lo_len, h[i]);
    end
    wr(ADDR_CPU_CTRL, 8'h03);
    repeat (30) @(posedge core_clk);
    rd(ADDR_CPU_CTRL); chk8(d, {2'h0, SPEED_12, 4'h3});
    chkn(hi_len, HALF_12); chkn(lo_len, HALF_12);
  endtask : t_speed
  task automatic t_pin;
    wr(ADDR_CPU_CTRL, 8'h04);
    repeat (3) @(posedge core_clk);
    repeat (8) @(negedge core_clk) chk8(clk_pin_out, !cpu_clock);
    wr(ADDR_CPU_CTRL, 8'h08);
    repeat (3) @(negedge core_clk);
    chk8(clk_pin_oe, 1'b0); chk8(clk_pin_out, cpu_clock);
    wr(4'hF, 8'hFF); rd(4'hF); chk8(d, 8'h00);
    wr(ADDR_CPU_CTRL, 8'h00);
    repeat (3) @(negedge core_clk);
    chk8(clk_pin_oe, 1'b1);
  endtask : t_pin
  task automatic t_ticks;
    logic [7:0] cfg[3] = '{8'h00, 8'h05, 8'h06};
    int         base, n;
    base = int'(BAUD_CNT_12) * 2 * int'(HALF_12);
    foreach (cfg[j])
    begin
      wr(ADDR_CPU_CTRL, {7'h0, j[0]} << 1);
      wr(ADDR_SER_CTRL, cfg[j]);
      gap(0, n); chkn(n, base * (1 + cfg[j][0]));
      gap(1, n); chkn(n, base * (1 + cfg[j][1]));
      gap(2, n); chkn(n, 2 * int'(HALF_12) * int'(cfg[j][2] ?
        SCL_FAST_12 : SCL_STD_12));
    end
  endtask : t_ticks
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (80000) @(posedge core_clk);
    mismatches++;
    end_sim;
  end
  initial
  begin
    reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0;
    reg_addr = '0; reg_wdata = '0;
    repeat (8) @(posedge core_clk);
    chk8(clk_pin_oe, 1'b1);
    reset <= 1'b0;
    t_speed;
    t_pin;
    t_ticks;
    end_sim;
  end
endmodule : tb_cpu_clock_gen
